// *** include/sasrm_pkg.sv ***
// Constants, types and shared helpers of the converter serial readout block.
// Assumes a 20 MHz core clock and a host-driven shift clock on its own domain.
`default_nettype none

package sasrm_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int RESULT_BITS    = 16;
	localparam int EDGE_CNT_BITS  = 6;
	// Deep enough that a chained bit survives a busy frame of lag
	localparam int SLOT_DEPTH     = 32;
	localparam int SLOT_IDX_BITS  = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS          = 50;
	// Maximum conversion time, plain default
	localparam int CONV_TIME_NS           = 3000;
	localparam int CONV_CYCLES            = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CNT_BITS          = $clog2(CONV_CYCLES + 1);
	localparam int QUIET_BEFORE_SAMPLE_NS = 25;
	localparam int QUIET_AFTER_SAMPLE_NS  = 10;
	localparam int QUIET_BEFORE_CYCLES    =
		(QUIET_BEFORE_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUIET_AFTER_CYCLES     =
		(QUIET_AFTER_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Frame lengths and reset values
	// ----------------------------------------------------------------
	localparam logic [EDGE_CNT_BITS-1:0] FRAME_LEN_PLAIN = 6'h10;
	localparam logic [EDGE_CNT_BITS-1:0] FRAME_LEN_BUSY  = 6'h11;
	localparam logic [RESULT_BITS-1:0]   RESULT_RESET    = 16'h0000;
	localparam logic [EDGE_CNT_BITS-1:0] EDGE_CNT_RESET  = 6'h00;
	localparam logic [SLOT_DEPTH-1:0]    SLOT_RESET      = 32'h00000000;

	typedef enum logic {SASRM_ACQUIRE, SASRM_CONVERT} sasrm_state_t;

	// ----------------------------------------------------------------
	// Gray code helpers
	// ----------------------------------------------------------------
	function automatic logic [EDGE_CNT_BITS-1:0] sasrm_bin2gray(
		input logic [EDGE_CNT_BITS-1:0] bin);
		return bin ^ (bin >> 1);
	endfunction : sasrm_bin2gray

	function automatic logic [EDGE_CNT_BITS-1:0] sasrm_gray2bin(
		input logic [EDGE_CNT_BITS-1:0] gray);
		logic [EDGE_CNT_BITS-1:0] bin;
		bin[EDGE_CNT_BITS-1] = gray[EDGE_CNT_BITS-1];
		for (int i = EDGE_CNT_BITS - 2; i >= 0; i--)
		begin
			bin[i] = bin[i+1] ^ gray[i];
		end
		return bin;
	endfunction : sasrm_gray2bin

endpackage : sasrm_pkg

`default_nettype wire

// *** include/sasrm_link_if.sv ***
// Carrier between the shift-clock edge counter and the core readout logic.
// Assumes the package is compiled first.
`default_nettype none

interface sasrm_link_if;
	import sasrm_pkg::*;

	logic [EDGE_CNT_BITS-1:0] edgeGray;
	logic [SLOT_DEPTH-1:0]    sdiSlot;

	modport link (output edgeGray, output sdiSlot);
	modport core (input edgeGray, input sdiSlot);
endinterface : sasrm_link_if

`default_nettype wire

// *** hw/sasrm_link_counter.sv ***
// Shift-clock domain: counts falling edges in gray code, records serial input.
// Assumes the shift clock stands still between frames; count survives that.
`default_nettype none

module sasrm_link_counter
	import sasrm_pkg::*;
(
	input  wire logic    shiftClk,
	input  wire logic    rst,
	input  wire logic    serialInSelect,
	sasrm_link_if.link   link
);

	logic [EDGE_CNT_BITS-1:0] cntBin_q;
	logic [EDGE_CNT_BITS-1:0] cntBin_d;
	logic [EDGE_CNT_BITS-1:0] gray_q;
	logic [EDGE_CNT_BITS-1:0] gray_d;
	logic [SLOT_DEPTH-1:0]    slot_q;
	logic [SLOT_DEPTH-1:0]    slot_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		cntBin_d = cntBin_q + 6'h01;
		gray_d   = sasrm_bin2gray(cntBin_d);
		slot_d   = slot_q;
		// Upstream bit taken before the count moves on
		slot_d[cntBin_q[SLOT_IDX_BITS-1:0]] = serialInSelect; // R18
	end

	// ----------------------------------------------------------------
	// Registers on falling shift edges
	// ----------------------------------------------------------------
	always_ff @(negedge shiftClk or posedge rst)
	begin
		if (rst)
		begin
			cntBin_q <= EDGE_CNT_RESET;
			gray_q   <= EDGE_CNT_RESET;
			slot_q   <= SLOT_RESET;
		end
		else
		begin
			cntBin_q <= cntBin_d; // R17
			gray_q   <= gray_d;
			slot_q   <= slot_d;
		end
	end

	assign link.edgeGray = gray_q;
	assign link.sdiSlot  = slot_q;

endmodule : sasrm_link_counter

`default_nettype wire

// *** hw/sasrm_readout.sv ***
// Conversion control and serial result readout with select-line and chain modes.
// Assumes pins arrive asynchronously; the shift clock is a second clock domain.
//
// Function
// R1 - Six setups: three-wire, four-wire select, chain; each with or without busy bit.
// R2 - Serial input level at trigger rise: high selects select-line, low selects chain.
// R3 - Serial input tied to trigger is seen low at the rise, giving chain mode.
// R4 - Three-wire host uses only trigger, shift clock and serial output.
// R5 - Four-wire: serial input gates readback independently of the trigger.
// R6 - Chain: shared trigger and shift clock, outputs feed next inputs.
// R7 - Without busy bit host waits the maximum conversion time before reading.
// R8 - With busy bit enabled a busy bit on the output marks conversion end.
// R9 - With busy bit host gives one extra shift edge to flush it.
// R10 - Select-line mode: busy on if trigger or serial input low at completion.
// R11 - Chain mode: busy on if shift clock high at trigger rise.
// R12 - Host keeps shift clock and serial input quiet around the trigger rise.
// R13 - Host confines activity to after conversion or its first half.
// R14 - Output bit held across both shift edges; host best samples on fall.
// R15 - Result is 16-bit straight binary, 0000 zero to FFFF full scale.
// R16 - Trigger rise starts conversion and latches the mode together.
// R17 - Serial output changes only after falling shift edges; here it also changes at conversion end and when a conversion starts.
// R18 - Chain mode passes upstream result from serial input onto serial output.
// R19 - Result leaves most significant bit first, one per falling edge.
// R20 - Result held unchanged until read or next conversion starts.
`default_nettype none

module sasrm_readout
	import sasrm_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   shiftClk,
	input  wire logic                   conversionTrigger,
	input  wire logic                   serialInSelect,
	input  wire logic [RESULT_BITS-1:0] sampleCode,
	output logic                        serialResultOut,
	output logic                        serialResultOutOe,
	output logic                        converting,
	output logic                        daisyMode,
	output logic                        busyIndicatorOn
);

	// ----------------------------------------------------------------
	// Shift-clock domain
	// ----------------------------------------------------------------
	sasrm_link_if linkBus ();

	sasrm_link_counter u_link (
		.shiftClk       (shiftClk),
		.rst            (rst),
		.serialInSelect (serialInSelect),
		.link           (linkBus.link)
	);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic                     trigMeta_q;
	logic                     trigSync_q;
	logic                     sdiMeta_q;
	logic                     sdiSync_q;
	logic                     sclkMeta_q;
	logic                     sclkSync_q;
	logic [EDGE_CNT_BITS-1:0] grayMeta_q;
	logic [EDGE_CNT_BITS-1:0] graySync_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			trigMeta_q <= 1'b0;
			trigSync_q <= 1'b0;
			sdiMeta_q  <= 1'b0;
			sdiSync_q  <= 1'b0;
			sclkMeta_q <= 1'b0;
			sclkSync_q <= 1'b0;
			grayMeta_q <= EDGE_CNT_RESET;
			graySync_q <= EDGE_CNT_RESET;
		end
		else
		begin
			trigMeta_q <= conversionTrigger;
			trigSync_q <= trigMeta_q;
			sdiMeta_q  <= serialInSelect;
			sdiSync_q  <= sdiMeta_q;
			sclkMeta_q <= shiftClk;
			sclkSync_q <= sclkMeta_q;
			grayMeta_q <= linkBus.edgeGray;
			graySync_q <= grayMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// Conversion and mode control
	// ----------------------------------------------------------------
	sasrm_state_t             state_q;
	sasrm_state_t             state_d;
	logic [CONV_CNT_BITS-1:0] convCnt_q;
	logic [CONV_CNT_BITS-1:0] convCnt_d;
	logic                     trigPrev_q;
	logic                     sdiPrev_q;
	logic                     sclkPrev_q;
	logic                     daisy_q;
	logic                     daisy_d;
	logic                     busyOn_q;
	logic                     busyOn_d;
	logic                     haveResult_q;
	logic                     haveResult_d;
	logic [RESULT_BITS-1:0]   result_q;
	logic [RESULT_BITS-1:0]   result_d;
	logic [EDGE_CNT_BITS-1:0] base_q;
	logic [EDGE_CNT_BITS-1:0] base_d;
	logic [EDGE_CNT_BITS-1:0] edgeBin;
	logic                     trigRise;
	logic                     convEnd;

	assign edgeBin  = sasrm_gray2bin(graySync_q);
	assign trigRise = trigSync_q && !trigPrev_q;
	assign convEnd  = (state_q == SASRM_CONVERT)
		&& (convCnt_q == CONV_CNT_BITS'(CONV_CYCLES - 1));

	always_comb
	begin
		state_d      = state_q;
		convCnt_d    = convCnt_q;
		daisy_d      = daisy_q;
		busyOn_d     = busyOn_q;
		haveResult_d = haveResult_q;
		result_d     = result_q;
		base_d       = base_q;
		case (state_q)
			SASRM_ACQUIRE:
			begin
				if (trigRise) // R16
				begin
					state_d      = SASRM_CONVERT;
					convCnt_d    = '0;
					haveResult_d = 1'b0;
					// Levels sampled while trigger still low
					daisy_d      = !sdiPrev_q; // R2 R3
					busyOn_d     = !sdiPrev_q && sclkPrev_q; // R11
				end
			end
			SASRM_CONVERT:
			begin
				if (convEnd)
				begin
					state_d      = SASRM_ACQUIRE;
					haveResult_d = 1'b1;
					result_d     = sampleCode; // R15 R20
					base_d       = edgeBin;
					if (!daisy_q)
					begin
						busyOn_d = !trigSync_q || !sdiSync_q; // R10
					end
				end
				else
				begin
					convCnt_d = convCnt_q + CONV_CNT_BITS'(1);
				end
			end
			default:
			begin
				state_d = SASRM_ACQUIRE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q      <= SASRM_ACQUIRE;
			convCnt_q    <= '0;
			trigPrev_q   <= 1'b0;
			sdiPrev_q    <= 1'b0;
			sclkPrev_q   <= 1'b0;
			daisy_q      <= 1'b0;
			busyOn_q     <= 1'b0;
			haveResult_q <= 1'b0;
			result_q     <= RESULT_RESET;
			base_q       <= EDGE_CNT_RESET;
		end
		else
		begin
			state_q      <= state_d;
			convCnt_q    <= convCnt_d;
			trigPrev_q   <= trigSync_q;
			sdiPrev_q    <= sdiSync_q;
			sclkPrev_q   <= sclkSync_q;
			daisy_q      <= daisy_d;
			busyOn_q     <= busyOn_d;
			haveResult_q <= haveResult_d;
			result_q     <= result_d;
			base_q       <= base_d;
		end
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	logic                     sdo_q;
	logic                     sdo_d;
	logic                     sdoOe_q;
	logic                     sdoOe_d;
	logic [EDGE_CNT_BITS-1:0] pos;
	logic [EDGE_CNT_BITS-1:0] frameLen;
	logic [EDGE_CNT_BITS-1:0] bitIdx;
	logic [EDGE_CNT_BITS-1:0] slotPtr;
	logic                     selected;

	always_comb
	begin
		pos      = edgeBin - base_q;
		frameLen = busyOn_q ? FRAME_LEN_BUSY : FRAME_LEN_PLAIN;
		bitIdx   = frameLen - pos - 6'h01;
		slotPtr  = edgeBin - frameLen;
		selected = !trigSync_q || !sdiSync_q; // R5
		sdo_d    = 1'b0;
		sdoOe_d  = 1'b0;
		if ((state_q == SASRM_ACQUIRE) && haveResult_q)
		begin
			if (busyOn_q && (pos == EDGE_CNT_RESET))
			begin
				sdo_d = 1'b0; // R8
			end
			else if (pos < frameLen)
			begin
				sdo_d = result_q[bitIdx[3:0]]; // R19
			end
			else
			begin
				sdo_d = linkBus.sdiSlot[slotPtr[SLOT_IDX_BITS-1:0]]; // R6 R18
			end
			sdoOe_d = daisy_q || (selected && (pos < frameLen)); // R1
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sdo_q   <= 1'b0;
			sdoOe_q <= 1'b0;
		end
		else
		begin
			sdo_q   <= sdo_d; // R14 R17
			sdoOe_q <= sdoOe_d;
		end
	end

	assign serialResultOut   = sdo_q;
	assign serialResultOutOe = sdoOe_q;
	assign converting        = (state_q == SASRM_CONVERT);
	assign daisyMode         = daisy_q;
	assign busyIndicatorOn   = busyOn_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int CONV_LAST = CONV_CYCLES - 1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_mode_latch: assert property ( // R2
		(trigRise && !converting) |=> (daisyMode == !$past(sdiPrev_q)))
		else $error("mode not latched from serial input");

	chk_conv_start: assert property ( // R16
		(trigRise && !converting) |=> converting)
		else $error("trigger rise did not start conversion");

	chk_conv_length: assert property ( // R16
		$rose(converting) |-> ##CONV_LAST converting ##1 !converting)
		else $error("conversion length wrong");

	chk_result_take: assert property ( // R15
		$fell(converting) |-> (result_q == $past(sampleCode)))
		else $error("result not taken at conversion end");

	chk_result_hold: assert property ( // R20
		(!converting && !$past(converting)) |-> $stable(result_q))
		else $error("result changed outside conversion end");

	chk_busy_select: assert property ( // R10
		(convEnd && !daisy_q) |=> (busyIndicatorOn == $past(selected)))
		else $error("select-line busy choice wrong");

	chk_busy_chain: assert property ( // R11
		(trigRise && !converting && !sdiPrev_q) |=> (busyIndicatorOn == $past(sclkPrev_q)))
		else $error("chain busy choice wrong");

	chk_hiz_conv: assert property ( // R8
		converting |=> !serialResultOutOe)
		else $error("output driven during conversion");

	chk_msb_first: assert property ( // R19
		(!converting && haveResult_q && !busyOn_q && pos == EDGE_CNT_RESET)
		|=> (serialResultOut == result_q[RESULT_BITS-1]))
		else $error("first bit is not the msb");

	chk_busy_bit: assert property ( // R8
		(!converting && haveResult_q && busyOn_q && pos == EDGE_CNT_RESET
			&& (daisy_q || selected)) |=> (serialResultOutOe && !serialResultOut))
		else $error("busy bit not shown");

	cov_chain_busy: cover property ($fell(converting) && daisyMode && busyIndicatorOn);
	cov_select_busy: cover property ($fell(converting) && !daisyMode && busyIndicatorOn);
	cov_full_frame: cover property (serialResultOutOe && pos == 6'h0F);
	cov_pass_through: cover property (daisyMode && serialResultOutOe && pos > FRAME_LEN_BUSY);

endmodule : sasrm_readout

`default_nettype wire

// *** tb/sasrm_host_model.sv ***
// Host side model: makes shift clock pulses and sees the output line.
// Assumes the bench core clock for pacing; released line has a pull-up.
`default_nettype none

module sasrm_host_model
(
	input  wire logic clk,
	input  wire logic serialResultOut,
	input  wire logic serialResultOutOe,
	output logic      shiftClk,
	output logic      lineLevel
);
	timeunit 1ns;
	timeprecision 100ps;

	// Released line floats to the pull-up
	assign lineLevel = serialResultOutOe ? serialResultOut : 1'b1;

	initial shiftClk = 1'b0;

	// Level set well clear of the trigger rise
	task automatic setLevel(input logic v);
		@(posedge clk);
		#9 shiftClk = v;
	endtask : setLevel

	// One 15 ns high pulse per bit, then clock stands low
	task automatic pulse();
		@(posedge clk);
		#9 shiftClk = 1'b1;
		#15 shiftClk = 1'b0;
		repeat (6) @(posedge clk);
	endtask : pulse
endmodule : sasrm_host_model

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the converter serial readout block.
// Assumes the package and the design files are compiled first.
`default_nettype none

`define CHK(nm, e, g) \
	begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb
	import sasrm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] CORNER [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};

	logic                   clk  = 1'b0;
	logic                   rst  = 1'b1;
	logic                   trig = 1'b0;
	logic                   serial_in_select  = 1'b1;
	logic [RESULT_BITS-1:0] code = 16'h0000;
	logic                   shiftClk, sOut, sOe, conv, daisy, busyOn, line;
	int                     errors = 0;
	int                     n_tests = 0;

	sasrm_readout u_sasrm_readout (.clk(clk), .rst(rst), .shiftClk(shiftClk),
		.conversionTrigger(trig), .serialInSelect(serial_in_select), .sampleCode(code),
		.serialResultOut(sOut), .serialResultOutOe(sOe), .converting(conv),
		.daisyMode(daisy), .busyIndicatorOn(busyOn));

	sasrm_host_model u_sasrm_host_model (.clk(clk), .serialResultOut(sOut),
		.serialResultOutOe(sOe), .shiftClk(shiftClk), .lineLevel(line));

	always #25 clk = ~clk;

	// ----------------------------------------------------------------
	// Expectations and helpers
	// ----------------------------------------------------------------
	function automatic logic expBit(logic [15:0] c, logic [15:0] up, logic bz, int p);
		int q;
		q = p - int'(bz);
		if (bz && p == 0)
			return 1'b0;
		if (q < RESULT_BITS)
			return c[RESULT_BITS-1-q];
		return up[2*RESULT_BITS-1-q];
	endfunction : expBit

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// Trigger rise, then wait out the conversion
	task automatic convert(input logic sdiR, input logic sclkR, input int mid);
		int k;
		@(posedge clk);
		trig <= 1'b0;
		serial_in_select  <= sdiR;
		u_sasrm_host_model.setLevel(sclkR);
		repeat (3) @(posedge clk);
		trig <= 1'b1;
		if (mid == 2)
			serial_in_select <= 1'b1;
		k = 0;
		while (conv !== 1'b1 && k < 10)
		begin
			@(negedge clk);
			k++;
		end
		if (k == 10)
		begin
			errors++;
			wrap_up();
		end
		k = 0;
		while (conv === 1'b1 && k < 200)
		begin
			@(negedge clk);
			k++;
			if (k == 5 && mid != 0)
			begin
				@(posedge clk);
				trig <= 1'b0;
				serial_in_select  <= (mid == 2) ? 1'b0 : serial_in_select;
			end
			if (k == 8 && mid == 2)
			begin
				@(posedge clk);
				trig <= 1'b1;
				serial_in_select  <= 1'b1;
			end
			if (k == 5 && sclkR)
				u_sasrm_host_model.setLevel(1'b0);
		end
		`CHK("convCycles", CONV_CYCLES, k)
		if (k == 200)
			wrap_up();
		@(negedge clk);
	endtask : convert

	// Kinds: 0 select no busy, 1 select busy, 2 chain, 3 chain busy, 4 tied
	task automatic scen(input logic [15:0] c, input logic [15:0] up, input int kind);
		logic bz;
		int   n;
		bz = (kind == 1 || kind == 3);
		n  = (kind == 2) ? 32 : 16 + int'(bz);
		@(posedge clk);
		code <= c;
		convert(kind < 2, kind == 3, (kind == 1) ? 1 : ((kind == 4) ? 2 : 0));
		`CHK("daisyMode", kind >= 2, daisy)
		`CHK("busyOn", bz, busyOn)
		if (kind == 0)
		begin
			`CHK("oeIdle", 1'b0, sOe)
			@(posedge clk);
			if (c[0])
				trig <= 1'b0;
			else
				serial_in_select <= 1'b0;
			repeat (4) @(negedge clk);
		end
		for (int i = 0; i < n; i++)
		begin
			if (kind == 2 && i < 16)
			begin
				@(posedge clk);
				serial_in_select <= up[15-i];
			end
			@(negedge clk);
			`CHK("serialOut", {1'b1, expBit(c, up, bz, i)}, {sOe, line})
			u_sasrm_host_model.pulse();
		end
		@(negedge clk);
		if (kind < 2)
			`CHK("oeDone", 1'b0, sOe)
		// Trigger left alone: raising it would start a conversion
		@(posedge clk);
		serial_in_select <= 1'b1;
		$display("test kind %0d done", kind);
	endtask : scen

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(79));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK("resetOuts", 5'h00, {sOut, sOe, conv, daisy, busyOn})
		foreach (CORNER[i])
			scen(CORNER[i], 16'h0000, 0);
		for (int i = 0; i < 5; i++)
			scen(16'($urandom()), 16'($urandom()), i);
		wrap_up();
	end
endmodule : tb

`default_nettype wire
